// ### design/pbrb_defs.svh
`ifndef PBRB_DEFS_SVH
`define PBRB_DEFS_SVH

// register indices; byte address is four times the index
`define PBRB_IDX_NODE 4'h0
`define PBRB_IDX_RSTGAP 4'h1
`define PBRB_IDX_EXTPORT 4'h2
`define PBRB_IDX_CAPS 4'h3
`define PBRB_IDX_LINKPWR 4'h4
`define PBRB_IDX_EVENTS 4'h5
`define PBRB_IDX_RSVD6 4'h6
`define PBRB_IDX_PAGESEL 4'h7
`define PBRB_IDX_W 4
`define PBRB_ADDR_W 12
`define PBRB_BYTE_LSB 2

// fixed capability values
`define PBRB_EXTENDED_VAL 3'h7
`define PBRB_TOTAL_PORTS_VAL 4'h1
`define PBRB_MAX_SPEED_VAL 3'h2
`define PBRB_DELAY_VAL 4'h0
`define PBRB_JITTER_VAL 3'h0

// reset values
`define PBRB_GAP_RESET 6'h3f
`define PBRB_LINK_ACTIVE_CTRL_RESET 1'h1
`define PBRB_PAGE_RESET 3'h0
`define PBRB_PORT_RESET 4'h0
`define PBRB_PWR_CLASS_RESET 3'h0
`define PBRB_PC_LOAD_WAIT 2'h3

// bus reset durations and clock rate
`define PBRB_CLK_PERIOD_NS 10
`define PBRB_LONG_RESET_US 166
`define PBRB_SHORT_RESET_NS 1300
`define PBRB_LONG_RESET_CYC ((`PBRB_LONG_RESET_US * 1000) / `PBRB_CLK_PERIOD_NS)
`define PBRB_SHORT_RESET_CYC (`PBRB_SHORT_RESET_NS / `PBRB_CLK_PERIOD_NS)

`endif

// ### design/pbrb_pkg.sv
package pbrb_pkg;
	typedef struct packed {
		logic [5:0] node_addr_id;
		logic root;
		logic cable_power_status;
	} pbrb_node_s;
	typedef struct packed {
		logic root_holdoff;
		logic long_reset_request;
		logic [5:0] gap_count;
	} pbrb_rstgap_s;
	typedef struct packed {
		logic [2:0] extended;
		logic rsvd;
		logic [3:0] total_ports;
	} pbrb_extport_s;
	typedef struct packed {
		logic [2:0] max_speed;
		logic rsvd;
		logic [3:0] delay;
	} pbrb_caps_s;
	typedef struct packed {
		logic link_active_ctrl;
		logic contender;
		logic [2:0] jitter;
		logic [2:0] pwr_class;
	} pbrb_linkpwr_s;
	typedef struct packed {
		logic watchdog;
		logic short_reset_request;
		logic loop;
		logic pwr_fail;
		logic timeout;
		logic port_event;
		logic enab_accel;
		logic enab_multi;
	} pbrb_events_s;
	typedef struct packed {
		logic [2:0] page;
		logic rsvd;
		logic [3:0] port;
	} pbrb_pagesel_s;
	// events reported by the port/arbitration core, same clock
	typedef struct packed {
		logic bus_reset;
		logic self_id_done;
		logic [5:0] self_id_addr;
		logic root_won;
		logic gap_load;
		logic [5:0] gap_value;
		logic loop_timeout;
		logic state_timeout;
		logic resume_start;
		logic xfer_busy;
	} pbrb_core_evt_s;
	// fields the core copies into its self-id packet and arbitration
	typedef struct packed {
		logic link_active;
		logic contender;
		logic [2:0] pwr_class;
		logic [5:0] gap_count;
		logic root_holdoff;
		logic enab_accel;
		logic enab_multi;
	} pbrb_selfid_s;
	typedef enum logic [1:0] {
		PBRB_RST_NONE = 2'b00,
		PBRB_RST_LONG = 2'b01,
		PBRB_RST_SHORT = 2'b10
	} pbrb_rst_e;
endpackage : pbrb_pkg

// ### design/pbrb_sync.sv
// two-stage synchroniser for pin inputs
module pbrb_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("pbrb_sync: WIDTH must be at least 1");
	end

	// first stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pbrb_sync

// ### design/pbrb_top.sv
`include "pbrb_defs.svh"
module pbrb_top
	import pbrb_pkg::*;
#(
	parameter int LONG_RESET_CYC = `PBRB_LONG_RESET_CYC,
	parameter int SHORT_RESET_CYC = `PBRB_SHORT_RESET_CYC,
	parameter int NUM_PORTS = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PBRB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cable_power_pin,
	input wire logic link_power_status_input,
	input wire logic [2:0] power_category_pins,
	input wire pbrb_core_evt_s core_evt,
	output pbrb_selfid_s selfid_o,
	output logic node_addr_valid,
	output logic phy_llc_enabled,
	output logic bus_reset_drive,
	output pbrb_rst_e bus_reset_kind
);
	localparam int CNT_W = $clog2(LONG_RESET_CYC + 1);

	initial begin
		if (LONG_RESET_CYC < 1 || SHORT_RESET_CYC < 1) $error("pbrb_top: reset counts too small");
		if (SHORT_RESET_CYC > LONG_RESET_CYC) $error("pbrb_top: short reset exceeds long");
		if (NUM_PORTS < 1 || NUM_PORTS > 15) $error("pbrb_top: NUM_PORTS out of range");
	end
	// synchronised pins
	logic cps_s;
	logic lps_s;
	logic [2:0] pc_s;
	logic cps_prev_q;

	pbrb_sync #(.WIDTH(1)) u_sync_cps (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(cable_power_pin),
		.sync_out(cps_s)
	);
	pbrb_sync #(.WIDTH(1)) u_sync_lps (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(link_power_status_input),
		.sync_out(lps_s)
	);
	pbrb_sync #(.WIDTH(3)) u_sync_pc (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(power_category_pins),
		.sync_out(pc_s)
	);

	// register state
	logic [5:0] node_addr_id_q;
	logic root_q;
	logic root_holdoff_q;
	logic long_reset_request_q;
	logic [5:0] gap_count_q;
	logic gap_updated_q;
	logic link_active_ctrl_q;
	logic contender_q;
	logic [2:0] pwr_class_q;
	logic [1:0] pc_wait_q;
	logic watchdog_q;
	logic short_reset_request_q;
	logic enab_accel_q;
	logic enab_multi_q;
	logic [2:0] page_q;
	logic [3:0] port_q;
	logic flag_loop;
	logic flag_pwr_fail;
	logic flag_timeout;
	logic flag_port_event;
	logic [CNT_W-1:0] rst_cnt_q;

	// apb decode; access phase lasts two cycles so pready comes from a flop
	logic acc_req;
	logic wr_fire;
	logic addr_ok;
	logic [`PBRB_IDX_W-1:0] idx;
	logic [7:0] wbyte;
	logic start_reset;

	assign acc_req = psel && penable && !pready;
	assign addr_ok = (paddr[`PBRB_ADDR_W-1:`PBRB_BYTE_LSB+`PBRB_IDX_W] == '0);
	assign idx = paddr[`PBRB_BYTE_LSB +: `PBRB_IDX_W];
	assign wr_fire = psel && penable && pready && pwrite && addr_ok && pstrb[0];
	assign wbyte = pwdata[7:0];

	// write views of each writable register layout
	pbrb_rstgap_s w_rstgap;
	pbrb_linkpwr_s w_linkpwr;
	pbrb_events_s w_events;
	pbrb_pagesel_s w_pagesel;
	assign w_rstgap = pbrb_rstgap_s'(wbyte);
	assign w_linkpwr = pbrb_linkpwr_s'(wbyte);
	assign w_events = pbrb_events_s'(wbyte);
	assign w_pagesel = pbrb_pagesel_s'(wbyte);

	logic wr_rstgap;
	logic wr_linkpwr;
	logic wr_events;
	logic wr_pagesel;
	assign wr_rstgap = wr_fire && (idx == `PBRB_IDX_RSTGAP);
	assign wr_linkpwr = wr_fire && (idx == `PBRB_IDX_LINKPWR);
	assign wr_events = wr_fire && (idx == `PBRB_IDX_EVENTS);
	assign wr_pagesel = wr_fire && (idx == `PBRB_IDX_PAGESEL);

	// read mux; only writable and status bits are stored, constants are wired
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (idx == `PBRB_IDX_NODE) begin
			rd_byte = pbrb_node_s'({node_addr_id_q, root_q, cps_s});
		end else if (idx == `PBRB_IDX_RSTGAP) begin
			rd_byte = pbrb_rstgap_s'({root_holdoff_q, long_reset_request_q, gap_count_q});
		end else if (idx == `PBRB_IDX_EXTPORT) begin
			rd_byte = pbrb_extport_s'({`PBRB_EXTENDED_VAL, 1'b0, `PBRB_TOTAL_PORTS_VAL});
		end else if (idx == `PBRB_IDX_CAPS) begin
			rd_byte = pbrb_caps_s'({`PBRB_MAX_SPEED_VAL, 1'b0, `PBRB_DELAY_VAL});
		end else if (idx == `PBRB_IDX_LINKPWR) begin
			rd_byte = pbrb_linkpwr_s'({link_active_ctrl_q, contender_q, `PBRB_JITTER_VAL,
				pwr_class_q});
		end else if (idx == `PBRB_IDX_EVENTS) begin
			rd_byte = pbrb_events_s'({watchdog_q, short_reset_request_q, flag_loop,
				flag_pwr_fail, flag_timeout, flag_port_event, enab_accel_q, enab_multi_q});
		end else if (idx == `PBRB_IDX_PAGESEL) begin
			rd_byte = pbrb_pagesel_s'({page_q, 1'b0, port_q});
		end else begin
			// reserved index 6 and the paged window; paged contents live elsewhere
			rd_byte = 8'h00;
		end
	end

	// apb answer: pready one cycle after the access phase opens
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (acc_req) begin
			pready <= 1'b1;
			pslverr <= !addr_ok;
			prdata <= (addr_ok && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	// node address and validity across bus reset and self-id
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_addr_id_q <= 6'h00;
			node_addr_valid <= 1'b0;
		end else if (core_evt.self_id_done) begin
			node_addr_id_q <= core_evt.self_id_addr;
			node_addr_valid <= 1'b1;
		end else if (core_evt.bus_reset) begin
			node_addr_valid <= 1'b0;
		end
	end

	// root flag; tree-id follows reset, so a same-cycle win is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			root_q <= 1'b0;
		end else if (core_evt.root_won) begin
			root_q <= 1'b1;
		end else if (core_evt.bus_reset) begin
			root_q <= 1'b0;
		end
	end

	// software controls unaffected by bus reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			root_holdoff_q <= 1'b0;
			link_active_ctrl_q <= `PBRB_LINK_ACTIVE_CTRL_RESET;
			contender_q <= 1'b0;
			watchdog_q <= 1'b0;
			enab_accel_q <= 1'b0;
			enab_multi_q <= 1'b0;
		end else begin
			if (wr_rstgap) root_holdoff_q <= w_rstgap.root_holdoff;
			if (wr_linkpwr) begin
				link_active_ctrl_q <= w_linkpwr.link_active_ctrl;
				contender_q <= w_linkpwr.contender;
			end
			if (wr_events) begin
				watchdog_q <= w_events.watchdog;
				enab_accel_q <= w_events.enab_accel;
				enab_multi_q <= w_events.enab_multi;
			end
		end
	end

	// page and port select; reserved bit dropped on write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_q <= `PBRB_PAGE_RESET;
			port_q <= `PBRB_PORT_RESET;
		end else if (wr_pagesel) begin
			page_q <= w_pagesel.page;
			port_q <= w_pagesel.port;
		end
	end

	// power class caught from synced pins on the third edge after release; only a write in that same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_wait_q <= 2'h0;
			pwr_class_q <= `PBRB_PWR_CLASS_RESET;
		end else begin
			if (pc_wait_q != `PBRB_PC_LOAD_WAIT) pc_wait_q <= pc_wait_q + 2'h1;
			if (wr_linkpwr) begin
				pwr_class_q <= w_linkpwr.pwr_class;
			end else if (pc_wait_q == `PBRB_PC_LOAD_WAIT - 2'h1) begin
				pwr_class_q <= pc_s;
			end
		end
	end

	// gap count; a bus reset with no update since the last one restores max
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_count_q <= `PBRB_GAP_RESET;
			gap_updated_q <= 1'b0;
		end else if (wr_rstgap) begin
			gap_count_q <= w_rstgap.gap_count;
			gap_updated_q <= 1'b1;
		end else if (core_evt.gap_load) begin
			gap_count_q <= core_evt.gap_value;
			gap_updated_q <= 1'b1;
		end else if (core_evt.bus_reset) begin
			if (!gap_updated_q) gap_count_q <= `PBRB_GAP_RESET;
			gap_updated_q <= 1'b0;
		end
	end

	// reset requests; a write in the clearing cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			long_reset_request_q <= 1'b0;
			short_reset_request_q <= 1'b0;
		end else begin
			if (wr_rstgap && w_rstgap.long_reset_request) begin
				long_reset_request_q <= 1'b1;
			end else if (core_evt.bus_reset || start_reset) begin
				long_reset_request_q <= 1'b0;
			end
			if (wr_events && w_events.short_reset_request) begin
				short_reset_request_q <= 1'b1;
			end else if (core_evt.bus_reset || start_reset) begin
				short_reset_request_q <= 1'b0;
			end
		end
	end

	// reset drive timer; waits for in-flight transfers, long wins over short
	assign start_reset = !bus_reset_drive && !core_evt.xfer_busy &&
		(long_reset_request_q || short_reset_request_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_reset_drive <= 1'b0;
			bus_reset_kind <= PBRB_RST_NONE;
			rst_cnt_q <= '0;
		end else if (start_reset) begin
			bus_reset_drive <= 1'b1;
			if (long_reset_request_q) begin
				bus_reset_kind <= PBRB_RST_LONG;
				rst_cnt_q <= CNT_W'(LONG_RESET_CYC - 1);
			end else begin
				bus_reset_kind <= PBRB_RST_SHORT;
				rst_cnt_q <= CNT_W'(SHORT_RESET_CYC - 1);
			end
		end else if (bus_reset_drive) begin
			if (rst_cnt_q == '0) begin
				bus_reset_drive <= 1'b0;
				bus_reset_kind <= PBRB_RST_NONE;
			end else begin
				rst_cnt_q <= rst_cnt_q - CNT_W'(1);
			end
		end
	end

	// power fail: falling edge of synced cable power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cps_prev_q <= 1'b0;
		end else begin
			cps_prev_q <= cps_s;
		end
	end

	// sticky flags, write-one-to-clear
	pbrb_w1c_flag u_flag_loop (
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(core_evt.loop_timeout),
		.clr_w1c(wr_events && w_events.loop),
		.flag_q(flag_loop)
	);
	pbrb_w1c_flag u_flag_pwr_fail (
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(cps_prev_q && !cps_s),
		.clr_w1c(wr_events && w_events.pwr_fail),
		.flag_q(flag_pwr_fail)
	);
	pbrb_w1c_flag u_flag_timeout (
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(core_evt.state_timeout),
		.clr_w1c(wr_events && w_events.timeout),
		.flag_q(flag_timeout)
	);
	pbrb_w1c_flag u_flag_port_event (
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(core_evt.resume_start && watchdog_q),
		.clr_w1c(wr_events && w_events.port_event),
		.flag_q(flag_port_event)
	);

	// self-id fields and link interface enable, registered for the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selfid_o <= '0;
			phy_llc_enabled <= 1'b0;
		end else begin
			selfid_o.link_active <= lps_s && link_active_ctrl_q;
			selfid_o.contender <= contender_q;
			selfid_o.pwr_class <= pwr_class_q;
			selfid_o.gap_count <= gap_count_q;
			selfid_o.root_holdoff <= root_holdoff_q;
			selfid_o.enab_accel <= enab_accel_q;
			selfid_o.enab_multi <= enab_multi_q;
			phy_llc_enabled <= lps_s;
		end
	end
endmodule : pbrb_top

// ### design/pbrb_w1c_flag.sv
// sticky event flag, cleared by writing one; a set in the clear cycle wins
module pbrb_w1c_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_evt,
	input wire logic clr_w1c,
	output logic flag_q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (set_evt) begin
			flag_q <= 1'b1;
		end else if (clr_w1c) begin
			flag_q <= 1'b0;
		end
	end
endmodule : pbrb_w1c_flag

// ### tb/pbrb_checker.sv
`include "pbrb_defs.svh"
module pbrb_checker
	import pbrb_pkg::*;
#(
	parameter int LONG_RESET_CYC = `PBRB_LONG_RESET_CYC,
	parameter int SHORT_RESET_CYC = `PBRB_SHORT_RESET_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PBRB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cable_power_pin,
	input wire logic link_power_status_input,
	input wire logic [2:0] power_category_pins,
	input wire pbrb_core_evt_s core_evt,
	input wire pbrb_selfid_s selfid_o,
	input wire logic node_addr_valid,
	input wire logic phy_llc_enabled,
	input wire logic bus_reset_drive,
	input wire pbrb_rst_e bus_reset_kind
);
	logic [31:0] drv_cnt_q;
	logic rd_q;
	// cycles the bus reset has been driven so far
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_cnt_q <= '0;
		end else begin
			drv_cnt_q <= bus_reset_drive ? drv_cnt_q + 32'h1 : 32'h0;
		end
	end
	// read answer of a mapped register
	assign rd_q = pready && !pwrite && paddr[11:6] == 6'h0;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_answer_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer late or long");
	unmapped_err_a: assert property (
		pready && paddr[11:6] != 6'h0 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	reserved_zero_a: assert property (
		rd_q && (paddr[5:2] == 4'h6 || paddr[5]) |-> prdata == 32'h0)
		else $error("reserved register not zero");
	upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	ext_ports_a: assert property (
		rd_q && paddr[5:2] == 4'h2 |-> prdata[7:0] == 8'he1)
		else $error("extension byte wrong");
	speed_delay_a: assert property (
		rd_q && paddr[5:2] == 4'h3 |-> prdata[7:0] == 8'h40)
		else $error("speed byte wrong");
	jitter_zero_a: assert property (rd_q && paddr[5:2] == 4'h4 |-> prdata[5:3] == 3'h0)
		else $error("jitter not zero");
	// five stable cycles cover the three-edge pin latency plus the reset release edge
	llc_follow_a: assert property (
		$stable(link_power_status_input) [*5] |-> phy_llc_enabled == link_power_status_input)
		else $error("llc state not following pin");
	link_gate_a: assert property (!phy_llc_enabled [*3] |-> !selfid_o.link_active)
		else $error("link active without power");
	node_invalid_a: assert property (
		core_evt.bus_reset && !core_evt.self_id_done |=> !node_addr_valid)
		else $error("node address valid after bus reset");
	node_valid_a: assert property (
		core_evt.self_id_done && !core_evt.bus_reset |=> node_addr_valid)
		else $error("node address not valid");
	busy_defers_a: assert property (
		core_evt.xfer_busy && !bus_reset_drive |=> !bus_reset_drive)
		else $error("bus reset during transfer");
	reset_kind_a: assert property (
		$rose(bus_reset_drive) |-> bus_reset_kind != PBRB_RST_NONE)
		else $error("bus reset without kind");
	reset_len_a: assert property (
		$fell(bus_reset_drive) |-> drv_cnt_q ==
		($past(bus_reset_kind) == PBRB_RST_LONG ? LONG_RESET_CYC : SHORT_RESET_CYC))
		else $error("bus reset length wrong");
endmodule : pbrb_checker

// ### tb/pbrb_core_model.sv
// port and arbitration core: one-cycle event pulses, busy as a level
module pbrb_core_model
	import pbrb_pkg::*;
(
	input wire logic pclk,
	output pbrb_core_evt_s core_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q = 1'b0;
	pbrb_core_evt_s ev;
	initial core_evt = '0;
	// pulse lasts exactly one cycle; busy level kept through it
	task automatic fire(input pbrb_core_evt_s p);
		@(posedge pclk);
		p.xfer_busy = busy_q;
		core_evt <= p;
		@(posedge pclk);
		p = '0;
		p.xfer_busy = busy_q;
		core_evt <= p;
	endtask : fire
	task automatic bus_rst();
		ev = '0;
		ev.bus_reset = 1'b1;
		fire(ev);
	endtask : bus_rst
	task automatic sid(input logic [5:0] a, input logic r);
		ev = '0;
		ev.self_id_done = 1'b1;
		ev.self_id_addr = a;
		ev.root_won = r;
		fire(ev);
	endtask : sid
	task automatic gap(input logic [5:0] v);
		ev = '0;
		ev.gap_load = 1'b1;
		ev.gap_value = v;
		fire(ev);
	endtask : gap
	task automatic flags(input logic l, input logic s, input logic r);
		ev = '0;
		ev.loop_timeout = l;
		ev.state_timeout = s;
		ev.resume_start = r;
		fire(ev);
	endtask : flags
	task automatic set_busy(input logic b);
		@(posedge pclk);
		busy_q = b;
		ev = '0;
		ev.xfer_busy = b;
		core_evt <= ev;
	endtask : set_busy
endmodule : pbrb_core_model

// ### tb/pbrb_top_test.sv
module pbrb_top_test
	import pbrb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG_CYC = 20;
	localparam int SHORT_CYC = 5;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cable_power_pin = 1'b1;
	logic link_power_status_input = 1'b1;
	logic [2:0] power_category_pins = 3'h5;
	pbrb_core_evt_s core_evt;
	pbrb_selfid_s selfid_o;
	logic node_addr_valid;
	logic phy_llc_enabled;
	logic bus_reset_drive;
	pbrb_rst_e bus_reset_kind;
	int num_errors = 0;
	int checks = 0;
	logic [7:0] rdat;
	logic err;
	logic [7:0] rst_tbl [8] = '{8'h01, 8'h3f, 8'he1, 8'h40, 8'h85, 8'h00, 8'h00, 8'h00};
	int ro_idx [3] = '{2, 3, 6};
	always #5 pclk = ~pclk;
	pbrb_top #(.LONG_RESET_CYC(LONG_CYC), .SHORT_RESET_CYC(SHORT_CYC)) pbrb_top_inst (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.cable_power_pin, .link_power_status_input, .power_category_pins, .core_evt, .selfid_o,
		.node_addr_valid, .phy_llc_enabled, .bus_reset_drive, .bus_reset_kind);
	pbrb_core_model pbrb_core_model_inst (.pclk, .core_evt);
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8
	// request held until pready is sampled high; never assumes a latency
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no latency assumed; only the watchdog ends a hung wait
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		apb(1'b1, {6'h0, i, 2'h0}, d);
	endtask : wr
	task automatic rdc(input logic [3:0] i, input logic [7:0] e);
		apb(1'b0, {6'h0, i, 2'h0}, 8'h0);
		chk8($sformatf("reg %0h", i), e, rdat);
	endtask : rdc
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick
	task automatic wait_drv(input logic lvl);
		repeat (200) begin
			tick(1);
			if (bus_reset_drive === lvl) break;
		end
	endtask : wait_drv
	task automatic wrap_up();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// whole run is about three hundred forty cycles
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		tick(3);
		chk8("valid", 8'h0, {7'h0, node_addr_valid});
		for (int i = 0; i < 8; i++)
			rdc(4'(i), rst_tbl[i]);
		// read-only and reserved bytes ignore writes
		foreach (ro_idx[k]) begin
			wr(4'(ro_idx[k]), 8'hff);
			rdc(4'(ro_idx[k]), rst_tbl[ro_idx[k]]);
		end
		// every page, unsupported port: paged window reads zero
		for (int p = 0; p < 8; p++) begin
			wr(4'h7, {3'(p), 5'h1f});
			rdc(4'h7, {3'(p), 5'h0f});
			rdc(4'(8 + p), 8'h00);
		end
		wr(4'h7, 8'h00);
		apb(1'b0, 12'h040, 8'h0);
		chk8("slverr", 8'h01, {7'h0, err});
		apb(1'b1, 12'h044, 8'h55);
		rdc(4'h1, 8'h3f);
		// gap count across bus resets
		wr(4'h1, 8'h2a);
		rdc(4'h1, 8'h2a);
		chk8("selfgap", 8'h2a, {2'h0, selfid_o.gap_count});
		pbrb_core_model_inst.bus_rst();
		rdc(4'h1, 8'h2a);
		pbrb_core_model_inst.bus_rst();
		rdc(4'h1, 8'h3f);
		pbrb_core_model_inst.gap(6'h15);
		pbrb_core_model_inst.bus_rst();
		rdc(4'h1, 8'h15);
		// a write without its byte strobe must not touch the gap count
		pstrb <= 4'he;
		wr(4'h1, 8'h2a);
		pstrb <= 4'hf;
		rdc(4'h1, 8'h15);
		// node address and root
		pbrb_core_model_inst.sid(6'h2b, 1'b1);
		tick(1);
		chk8("valid", 8'h01, {7'h0, node_addr_valid});
		rdc(4'h0, 8'haf);
		pbrb_core_model_inst.bus_rst();
		tick(1);
		chk8("valid", 8'h00, {7'h0, node_addr_valid});
		rdc(4'h0, 8'had);
		// event flags and cable power
		cable_power_pin <= 1'b0;
		tick(6);
		rdc(4'h0, 8'hac);
		pbrb_core_model_inst.flags(1'b1, 1'b1, 1'b1);
		rdc(4'h5, 8'h38);
		wr(4'h5, 8'h83);
		pbrb_core_model_inst.flags(1'b0, 1'b0, 1'b1);
		rdc(4'h5, 8'hbf);
		wr(4'h5, 8'hbf);
		rdc(4'h5, 8'h83);
		chk8("accel", 8'h03, {6'h0, selfid_o.enab_accel, selfid_o.enab_multi});
		cable_power_pin <= 1'b1;
		// link control, contender, power class into self-id
		wr(4'h4, 8'h40);
		tick(3);
		chk8("link", 8'h00, {7'h0, selfid_o.link_active});
		chk8("cont", 8'h01, {7'h0, selfid_o.contender});
		chk8("llc", 8'h01, {7'h0, phy_llc_enabled});
		wr(4'h4, 8'h87);
		tick(3);
		chk8("link", 8'h01, {7'h0, selfid_o.link_active});
		chk8("pwr", 8'h07, {5'h0, selfid_o.pwr_class});
		link_power_status_input <= 1'b0;
		tick(5);
		chk8("llc", 8'h00, {7'h0, phy_llc_enabled});
		chk8("link", 8'h00, {7'h0, selfid_o.link_active});
		link_power_status_input <= 1'b1;
		wr(4'h1, 8'hbf);
		tick(3);
		chk8("holdoff", 8'h01, {7'h0, selfid_o.root_holdoff});
		pbrb_core_model_inst.bus_rst();
		rdc(4'h1, 8'hbf);
		// long reset waits for the transfer in progress
		pbrb_core_model_inst.set_busy(1'b1);
		wr(4'h1, 8'h7f);
		tick(4);
		chk8("drive", 8'h00, {7'h0, bus_reset_drive});
		rdc(4'h1, 8'h7f);
		pbrb_core_model_inst.set_busy(1'b0);
		wait_drv(1'b1);
		chk8("kind", {6'h0, PBRB_RST_LONG}, {6'h0, bus_reset_kind});
		rdc(4'h1, 8'h3f);
		wait_drv(1'b0);
		wr(4'h5, 8'h40);
		wait_drv(1'b1);
		chk8("kind", {6'h0, PBRB_RST_SHORT}, {6'h0, bus_reset_kind});
		rdc(4'h5, 8'h00);
		wait_drv(1'b0);
		chk8("drive", 8'h00, {7'h0, bus_reset_drive});
		wrap_up();
	end
endmodule : pbrb_top_test
bind pbrb_top pbrb_checker #(.LONG_RESET_CYC(LONG_RESET_CYC), .SHORT_RESET_CYC(SHORT_RESET_CYC))
	pbrb_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
	.pready, .pslverr, .cable_power_pin, .link_power_status_input, .power_category_pins,
	.core_evt, .selfid_o, .node_addr_valid, .phy_llc_enabled, .bus_reset_drive, .bus_reset_kind);
